// [rtl/dar_pkg.sv]
// constants, types and field layout for the decimation average readout
//
// Notes on behaviour
// - codes 0..4 average 1,2,4,8,16 samples; host never writes codes 5 and up
// - averaged second pair result sits in a 24-bit read-only register
// - averaged first pair result sits in bits 23..0 of its own read-only register
// - each average uses exactly the selected number of consecutive samples
// - both average registers are read-only and read zero after reset
// - before the first reset the clock pin may be driven as an output
// - every reset selects external clock mode; mode before the first reset is unknown
// - clock pin stays high-impedance until internal mode with clock output is written
// - bit 5 of the control register switches averaging off (0) or on (1)
// - count select field is bits 3..1; other bits written as zero
package dar_pkg;
    localparam int DAR_DATA_W = 24;
    localparam int DAR_ADDR_W = 8;
    localparam int DAR_SEL_W = 3;
    localparam int DAR_SHIFT_MAX = 4;
    localparam int DAR_SUM_W = DAR_DATA_W + DAR_SHIFT_MAX;

    localparam logic [DAR_ADDR_W-1:0] DAR_ADDR_CLK_CTRL = 8'h23;
    localparam logic [DAR_ADDR_W-1:0] DAR_ADDR_AVG_CTRL = 8'h3D;
    localparam logic [DAR_ADDR_W-1:0] DAR_ADDR_SECOND_AVG = 8'h3F;
    localparam logic [DAR_ADDR_W-1:0] DAR_ADDR_FIRST_AVG = 8'h40;

    localparam int DAR_ENABLE_BIT = 5;
    localparam int DAR_SEL_LSB = 1;
    localparam int DAR_SEL_MSB = 3;
    localparam int DAR_INT_OSC_BIT = 0;
    localparam int DAR_CLK_OUT_EN_BIT = 1;

    localparam logic [DAR_DATA_W-1:0] DAR_RESET_VALUE = 24'h000000;
    localparam logic [DAR_SEL_W-1:0] DAR_SEL_RESET = 3'h0;
    localparam logic [DAR_SEL_W-1:0] DAR_SEL_LAST_LEGAL = 3'h4;

    typedef struct packed {
        logic [DAR_DATA_W-1:0] second;
        logic [DAR_DATA_W-1:0] first;
    } dar_pair_s;

    typedef struct packed {
        logic enable;
        logic [DAR_SEL_W-1:0] count_select;
    } dar_avg_ctrl_s;
endpackage : dar_pkg

// [rtl/dar_accum.sv]
// one averaging channel: running sum and atomic result register
`timescale 1ns/100ps
`default_nettype none
module dar_accum
    import dar_pkg::*;
#(
    parameter int DATA_W = DAR_DATA_W,
    parameter int SUM_W = DAR_SUM_W
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic clear_i,
    input wire logic valid_i,
    input wire logic last_i,
    input wire logic [DAR_SEL_W-1:0] shift_i,
    input wire logic [DATA_W-1:0] sample_i,
    output logic [DATA_W-1:0] average_o
);
    logic signed [SUM_W-1:0] sum_reg;
    logic [DATA_W-1:0] average_reg;
    wire logic signed [SUM_W-1:0] sample_ext = SUM_W'(signed'(sample_i));
    wire logic signed [SUM_W-1:0] total = sum_reg + sample_ext;
    wire logic signed [SUM_W-1:0] scaled = total >>> shift_i;

    always_ff @(posedge clock_i) begin
        if (!reset_n_i || clear_i) begin
            sum_reg <= '0;
        end else if (valid_i) begin
            sum_reg <= last_i ? '0 : total;
        end
    end

    // whole word replaced in one edge, never byte by byte
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            average_reg <= DAR_RESET_VALUE;
        end else if (valid_i && last_i && !clear_i) begin
            average_reg <= scaled[DATA_W-1:0];
        end
    end

    assign average_o = average_reg;
endmodule : dar_accum
`default_nettype wire

// [rtl/dar_top.sv]
// decimation average readout: control, averaging, result registers, clock pin
`timescale 1ns/100ps
`default_nettype none
module dar_top
    import dar_pkg::*;
#(
    parameter int DATA_W = DAR_DATA_W
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [DAR_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_write_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_read_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic sample_valid_i,
    input wire dar_pair_s sample_i,
    input wire logic full_power_down_i,
    input wire logic frontend_power_down_i,
    input wire logic clk_pin_i,
    output logic clk_pin_o,
    output logic clk_pin_oe_n_o,
    output logic clk_pin_level_o,
    output logic external_clock_sel_o,
    output logic average_ready_o
);
    // map count select code to a shift; codes above the table clamp to shift 4 (16 samples)
    function automatic logic [DAR_SEL_W-1:0] sel_to_shift(input logic [DAR_SEL_W-1:0] sel);
        sel_to_shift = (sel > DAR_SEL_LAST_LEGAL) ? DAR_SEL_LAST_LEGAL : sel;
    endfunction : sel_to_shift

    dar_avg_ctrl_s avg_ctrl_reg;
    logic int_osc_reg;
    logic clk_out_en_reg;
    logic [DAR_SHIFT_MAX-1:0] count_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic rvalid_reg;
    logic ready_reg;
    logic clk_out_reg;
    logic pin_sync1_reg;
    logic pin_sync2_reg;
    logic [DATA_W-1:0] first_avg;
    logic [DATA_W-1:0] second_avg;

    wire logic wr_avg_ctrl = reg_write_i && (reg_addr_i == DAR_ADDR_AVG_CTRL);
    wire logic wr_clk_ctrl = reg_write_i && (reg_addr_i == DAR_ADDR_CLK_CTRL);
    wire logic [DAR_SEL_W-1:0] shift = sel_to_shift(avg_ctrl_reg.count_select);
    wire logic [DAR_SHIFT_MAX-1:0] last_count = DAR_SHIFT_MAX'((1 << shift) - 1);
    wire logic window_last = (count_reg == last_count);
    wire logic take_sample = sample_valid_i && avg_ctrl_reg.enable;
    // a settings change restarts the window so no mixed window is averaged
    wire logic restart = !avg_ctrl_reg.enable || wr_avg_ctrl;
    wire logic powered_down = full_power_down_i || frontend_power_down_i;
    wire logic drive_pin = int_osc_reg && clk_out_en_reg && !powered_down;

    wire logic [DATA_W-1:0] avg_ctrl_view =
        DATA_W'({avg_ctrl_reg.enable, 1'b0, avg_ctrl_reg.count_select, 1'b0});
    wire logic [DATA_W-1:0] clk_ctrl_view = DATA_W'({clk_out_en_reg, int_osc_reg});
    logic [DATA_W-1:0] read_mux;
    always_comb begin
        unique case (reg_addr_i)
            DAR_ADDR_AVG_CTRL: read_mux = avg_ctrl_view;
            DAR_ADDR_CLK_CTRL: read_mux = clk_ctrl_view;
            DAR_ADDR_SECOND_AVG: read_mux = second_avg;
            DAR_ADDR_FIRST_AVG: read_mux = first_avg;
            default: read_mux = '0;
        endcase
    end

    // reserved bits dropped; host is expected to write them as zero
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            avg_ctrl_reg <= '{enable: 1'b0, count_select: DAR_SEL_RESET};
        end else if (wr_avg_ctrl) begin
            avg_ctrl_reg.enable <= reg_wdata_i[DAR_ENABLE_BIT];
            avg_ctrl_reg.count_select <= reg_wdata_i[DAR_SEL_MSB:DAR_SEL_LSB];
        end
    end

    // synchronous reset only: state before the first reset is unknown
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            int_osc_reg <= 1'b0;
            clk_out_en_reg <= 1'b0;
        end else if (wr_clk_ctrl) begin
            int_osc_reg <= reg_wdata_i[DAR_INT_OSC_BIT];
            clk_out_en_reg <= reg_wdata_i[DAR_CLK_OUT_EN_BIT];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i || restart) begin
            count_reg <= '0;
        end else if (take_sample) begin
            count_reg <= window_last ? '0 : count_reg + 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= take_sample && window_last && !restart;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= reg_read_i;
            if (reg_read_i) begin
                rdata_reg <= read_mux;
            end
        end
    end

    // internal clock out: divide by two while driving, low otherwise
    always_ff @(posedge clock_i) begin
        if (!reset_n_i || !drive_pin) begin
            clk_out_reg <= 1'b0;
        end else begin
            clk_out_reg <= !clk_out_reg;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            pin_sync1_reg <= 1'b0;
            pin_sync2_reg <= 1'b0;
        end else begin
            pin_sync1_reg <= clk_pin_i;
            pin_sync2_reg <= pin_sync1_reg;
        end
    end

    dar_accum #(.DATA_W(DATA_W), .SUM_W(DAR_SUM_W)) u_first (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .clear_i(restart),
        .valid_i(take_sample),
        .last_i(window_last),
        .shift_i(shift),
        .sample_i(sample_i.first),
        .average_o(first_avg)
    );

    dar_accum #(.DATA_W(DATA_W), .SUM_W(DAR_SUM_W)) u_second (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .clear_i(restart),
        .valid_i(take_sample),
        .last_i(window_last),
        .shift_i(shift),
        .sample_i(sample_i.second),
        .average_o(second_avg)
    );

    assign reg_rdata_o = rdata_reg;
    assign reg_rvalid_o = rvalid_reg;
    assign clk_pin_o = clk_out_reg;
    assign clk_pin_oe_n_o = !drive_pin;
    assign clk_pin_level_o = pin_sync2_reg;
    assign external_clock_sel_o = !int_osc_reg;
    assign average_ready_o = ready_reg;
endmodule : dar_top
`default_nettype wire

// [bench/dar_top_props.sv]
// assertion checker for the decimation average readout
`timescale 1ns/100ps
`default_nettype none
module dar_top_props
    import dar_pkg::*;
#(
    parameter int DATA_W = DAR_DATA_W
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [DAR_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_write_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_read_i,
    input wire logic reg_rvalid_o,
    input wire logic sample_valid_i,
    input wire logic full_power_down_i,
    input wire logic frontend_power_down_i,
    input wire logic clk_pin_o,
    input wire logic clk_pin_oe_n_o,
    input wire logic external_clock_sel_o,
    input wire logic average_ready_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    logic en_reg;
    logic [DAR_SEL_W-1:0] sel_reg;
    wire wr_ctrl = reg_write_i && reg_addr_i == DAR_ADDR_AVG_CTRL;
    // shadow of the averaging control
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            en_reg <= 1'b0;
            sel_reg <= 3'h0;
        end else if (wr_ctrl) begin
            en_reg <= reg_wdata_i[DAR_ENABLE_BIT];
            sel_reg <= reg_wdata_i[DAR_SEL_MSB:DAR_SEL_LSB];
        end
    end
    sequence s_one_sample;
        sample_valid_i && en_reg && sel_reg == 3'h0 && !wr_ctrl;
    endsequence
    chk_read_answer: assert property (reg_read_i |=> reg_rvalid_o)
        else $error("read not answered");
    chk_answer_cause: assert property (reg_rvalid_o |-> $past(reg_read_i))
        else $error("answer without read");
    chk_ext_default: assert property ($rose(reset_n_i) |-> external_clock_sel_o && clk_pin_oe_n_o)
        else $error("clock mode not default");
    chk_drive_internal: assert property (!clk_pin_oe_n_o |-> !external_clock_sel_o)
        else $error("pin driven in external mode");
    chk_pd_release: assert property (full_power_down_i || frontend_power_down_i |-> clk_pin_oe_n_o)
        else $error("pin driven in power down");
    chk_pin_toggle: assert property (!$past(clk_pin_oe_n_o) |-> clk_pin_o != $past(clk_pin_o))
        else $error("pin clock stuck");
    chk_single_ready: assert property (s_one_sample |=> average_ready_o)
        else $error("single sample window missed");
    chk_ready_cause: assert property (average_ready_o |-> $past(sample_valid_i))
        else $error("ready without sample");
    chk_idle_quiet: assert property (sample_valid_i && !en_reg |=> !average_ready_o)
        else $error("update while disabled");
endmodule : dar_top_props
bind dar_top dar_top_props #(.DATA_W(DATA_W)) i_props (.*);
`default_nettype wire

// [bench/dar_clk_src.sv]
// external clock source on the host side of the clock pin
`timescale 1ns/100ps
`default_nettype none
module dar_clk_src (
    input wire logic clock_i,
    input wire logic power_down_i,
    output logic ext_clk_o
);
    always @(posedge clock_i) ext_clk_o <= power_down_i ? 1'b0 : (ext_clk_o !== 1'b1);
endmodule : dar_clk_src
`default_nettype wire

// [bench/dar_top_tb_top.sv]
// self-checking bench for the decimation average readout
`timescale 1ns/100ps
`default_nettype none
module dar_top_tb_top
    import dar_pkg::*;
;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic sample_valid_i = 1'b0;
    logic full_power_down_i = 1'b0;
    logic frontend_power_down_i = 1'b0;
    logic [23:0] reg_wdata_i = 24'h000000;
    logic [23:0] reg_rdata_o, av1 = 24'h0, av2 = 24'h0;
    dar_pair_s sample_i = '0;
    logic reg_rvalid_o, clk_pin_o, clk_pin_oe_n_o, external_clock_sel_o, average_ready_o, ext_clk;
    logic pin_level;
    wire clk_pin_i = clk_pin_oe_n_o ? ext_clk : clk_pin_o;
    int n_errors = 0;
    int n_tests = 0;
    int q1[$], q2[$];
    dar_top i_dut (.*, .clk_pin_level_o(pin_level));
    dar_clk_src i_src (.clock_i(clock_i), .power_down_i(full_power_down_i | frontend_power_down_i),
        .ext_clk_o(ext_clk));
    initial forever #25 clock_i = ~clock_i;
    task report_and_stop;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task tick;
        @(posedge clock_i);
        #5;
    endtask : tick
    task wr(input logic [7:0] a, input logic [23:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_write_i = 1'b1;
        tick();
        reg_write_i = 1'b0;
        tick();
    endtask : wr
    task rd(input string nm, input logic [7:0] a, input logic [23:0] exp);
        reg_addr_i = a;
        reg_read_i = 1'b1;
        tick();
        reg_read_i = 1'b0;
        chk("rvalid", {23'h0, reg_rvalid_o}, 24'h1);
        chk(nm, reg_rdata_o, exp);
        tick();
    endtask : rd
    task run(input int sel, input logic en);
        int s1, s2;
        wr(DAR_ADDR_AVG_CTRL, {18'h0, en, 1'b0, sel[2:0], 1'b0});
        rd("control", DAR_ADDR_AVG_CTRL, {18'h0, en, 1'b0, sel[2:0], 1'b0});
        for (int i = 0; i < (1 << sel); i++) begin
            s1 = $urandom() << 8;
            s2 = $urandom() << 8;
            q1.push_back(s1 >>> 8);
            q2.push_back(s2 >>> 8);
            sample_i = {24'(s2 >>> 8), 24'(s1 >>> 8)};
            sample_valid_i = 1'b1;
            tick();
        end
        sample_valid_i = 1'b0;
        chk("ready", {23'h0, average_ready_o}, {23'h0, en});
        if (en) begin
            av1 = 24'(q1.sum() >>> sel);
            av2 = 24'(q2.sum() >>> sel);
        end
        q1.delete();
        q2.delete();
        rd("first", DAR_ADDR_FIRST_AVG, av1);
        rd("second", DAR_ADDR_SECOND_AVG, av2);
    endtask : run
    initial begin
        #(50 * 2000);
        n_errors++;
        report_and_stop();
    end
    initial begin
        void'($urandom(87));
        repeat (16) tick();
        reset_n_i = 1'b1;
        chk("ext sel", {23'h0, external_clock_sel_o}, 24'h1);
        chk("oe_n", {23'h0, clk_pin_oe_n_o}, 24'h1);
        rd("second", DAR_ADDR_SECOND_AVG, 24'h0);
        wr(DAR_ADDR_FIRST_AVG, 24'hFFFFFF);
        rd("first", DAR_ADDR_FIRST_AVG, 24'h0);
        rd("unmapped", 8'h00, 24'h0);
        $display("test reset done");
        for (int s = 0; s <= 4; s++) run(s, 1'b1);
        run(2, 1'b0);
        $display("test averaging done");
        wr(DAR_ADDR_CLK_CTRL, 24'h000003);
        chk("oe_n", {23'h0, clk_pin_oe_n_o}, 24'h0);
        repeat (4) tick();
        full_power_down_i = 1'b1;
        tick();
        chk("oe_n", {23'h0, clk_pin_oe_n_o}, 24'h1);
        full_power_down_i = 1'b0;
        frontend_power_down_i = 1'b1;
        tick();
        chk("oe_n", {23'h0, clk_pin_oe_n_o}, 24'h1);
        repeat (2) tick();
        chk("pin level", {23'h0, pin_level}, 24'h0);
        frontend_power_down_i = 1'b0;
        reset_n_i = 1'b0;
        repeat (2) tick();
        reset_n_i = 1'b1;
        chk("ext sel", {23'h0, external_clock_sel_o}, 24'h1);
        rd("first", DAR_ADDR_FIRST_AVG, 24'h0);
        $display("test clock pin done");
        report_and_stop();
    end
endmodule : dar_top_tb_top
`default_nettype wire
